// [src/i2c_host_pkg.sv]
package i2c_host_pkg;
   localparam logic [5:0] addr_fixed_bits = 6'h0c; // Upper six address bits
   localparam logic read_dir = 1'b1;
   localparam logic write_dir = 1'b0;
   localparam logic [7:0] incr_flag = 8'h80;
   localparam int clk_hz = 50000000;
   localparam int fast_scl_hz = 400000;
   localparam int std_scl_hz = 100000;
   // Quarter-period counts of the generated bus clock
   localparam int fast_quarter = clk_hz / (fast_scl_hz * 4);
   localparam int std_quarter = clk_hz / (std_scl_hz * 4);
   localparam int filt_len = 3;
   localparam int max_bytes = 16;

   typedef struct packed {
      logic is_read;     // 1 read, 0 write
      logic strap;       // Level of the device address strap
      logic incr;        // Set the auto-increment flag
      logic [6:0] reg_addr;
      logic [4:0] count; // Bytes to move, 1..31; a count of 0 is not accepted
   } cmd_t;

   typedef struct packed {
      logic done;
      logic nack;        // Device failed to acknowledge
      logic [7:0] data;
      logic data_valid;
   } rsp_t;
endpackage

// [src/line_filter.sv]
`timescale 1ns/1ns
// Two-stage synchroniser followed by a majority-free persistence filter
module line_filter #(
   parameter int len = i2c_host_pkg::filt_len
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic s1_q, s2_q;
   logic [$clog2(len+1)-1:0] cnt_q;

   ////////////////////////////////////////////////////////////
   // Synchroniser; first stage read only by second
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
      end
   end

   // Level must persist len cycles; short glitches never reach dout
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         dout <= 1'b1;
      end else if (s2_q == dout) begin
         cnt_q <= '0;
      end else if (cnt_q == ($clog2(len+1))'(len - 1)) begin
         cnt_q <= '0;
         dout <= s2_q;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule

// [src/i2c_host.sv]
`timescale 1ns/1ns
// Two-wire bus master that reads and writes the sensor register space
module i2c_host #(
   parameter int quarter_fast = i2c_host_pkg::fast_quarter,
   parameter int quarter_std = i2c_host_pkg::std_quarter
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire i2c_host_pkg::cmd_t cmd,
   input wire logic fast_mode,
   input wire logic [7:0] wr_data,
   output logic wr_take,
   output logic cmd_ready,
   output i2c_host_pkg::rsp_t rsp,
   output logic bus_busy,
   output logic select_out,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n
);
   typedef enum logic [3:0] {
      st_idle = 4'b0000, st_start = 4'b0001, st_bit = 4'b0010, st_ack = 4'b0011,
      st_rstart = 4'b0100, st_stop = 4'b0101, st_done = 4'b0110
   } state_t;

   typedef enum logic [1:0] {
      ph_addr_w = 2'b00, ph_sub = 2'b01, ph_addr_r = 2'b10, ph_data = 2'b11
   } phase_t;

   state_t state_q;
   phase_t phase_q;
   i2c_host_pkg::cmd_t cmd_q;
   logic [7:0] shift_q;
   logic [2:0] bit_q;
   logic [1:0] qtr_q;
   logic [15:0] tick_q;
   logic [4:0] left_q;
   logic nack_q;
   logic scl_f, sda_f, scl_f_q, sda_f_q;
   logic tick, stretched, start_seen, stop_seen;
   logic [15:0] quarter;

   ////////////////////////////////////////////////////////////
   // Filtered views of both lines
   line_filter #(.len(i2c_host_pkg::filt_len)) u_scl (.clk(clk), .rst(rst), .din(scl_in), .dout(scl_f));
   line_filter #(.len(i2c_host_pkg::filt_len)) u_sda (.clk(clk), .rst(rst), .din(sda_in), .dout(sda_f));

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
      end else begin
         scl_f_q <= scl_f;
         sda_f_q <= sda_f;
      end
   end

   assign start_seen = scl_f && sda_f_q && !sda_f;
   assign stop_seen = scl_f && !sda_f_q && sda_f;

   // Bus busy from any start to the next stop, ours or another master's
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_busy <= 1'b0;
      end else if (start_seen) begin
         bus_busy <= 1'b1;
      end else if (stop_seen) begin
         bus_busy <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////
   // Quarter-bit timebase; standard rate kept for slow buses
   assign quarter = fast_mode ? 16'(quarter_fast) : 16'(quarter_std);
   // While we release the clock but it still reads low, the device stretches
   assign stretched = scl_out && !scl_f;
   assign tick = (tick_q == quarter - 16'h0001) && !stretched;

   always_ff @(posedge clk) begin
      if (rst || state_q == st_idle) begin
         tick_q <= '0;
      end else if (stretched) begin
         tick_q <= '0;
      end else if (tick) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_q + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_q == st_idle) begin
         qtr_q <= '0;
      end else if (tick) begin
         qtr_q <= qtr_q + 2'h1;
      end
   end

   // Port select held high: two-wire mode chosen for the device
   always_ff @(posedge clk) begin
      if (rst) begin
         select_out <= 1'b0;
      end else begin
         select_out <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////
   // Sequencer: quarter 0 drives data with clock low, 1-2 clock high, 3 clock low
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= st_idle;
         phase_q <= ph_addr_w;
         cmd_q <= '0;
         shift_q <= '0;
         bit_q <= '0;
         left_q <= '0;
         nack_q <= 1'b0;
         scl_out <= 1'b1;
         sda_out <= 1'b1;
         rsp <= '0;
         wr_take <= 1'b0;
      end else begin
         rsp.done <= 1'b0;
         rsp.data_valid <= 1'b0;
         wr_take <= 1'b0;
         unique case (state_q)
            st_idle: begin
               scl_out <= 1'b1;
               sda_out <= 1'b1;
               if (cmd_valid && !bus_busy && cmd.count != 5'h00) begin
                  cmd_q <= cmd;
                  nack_q <= 1'b0;
                  state_q <= st_start;
               end
            end
            st_start, st_rstart: begin
               // Data falls while clock high, then clock goes low
               if (tick) begin
                  unique case (qtr_q)
                     2'h0: begin
                        scl_out <= 1'b1;
                        sda_out <= 1'b1;
                     end
                     2'h1: sda_out <= 1'b0;
                     2'h2: scl_out <= 1'b0;
                     2'h3: begin
                        phase_q <= (state_q == st_rstart) ? ph_addr_r : ph_addr_w;
                        shift_q <= {i2c_host_pkg::addr_fixed_bits, cmd_q.strap,
                                    (state_q == st_rstart) ? i2c_host_pkg::read_dir : i2c_host_pkg::write_dir};
                        bit_q <= 3'h7;
                        left_q <= cmd_q.count;
                        state_q <= st_bit;
                     end
                  endcase
               end
            end
            st_bit: begin
               if (tick) begin
                  unique case (qtr_q)
                     2'h0: sda_out <= (phase_q == ph_data && cmd_q.is_read) ? 1'b1 : shift_q[7];
                     2'h1: scl_out <= 1'b1;
                     2'h2: if (phase_q == ph_data && cmd_q.is_read) shift_q <= {shift_q[6:0], sda_f};
                     2'h3: begin
                        scl_out <= 1'b0;
                        if (!(phase_q == ph_data && cmd_q.is_read)) shift_q <= {shift_q[6:0], 1'b0};
                        if (bit_q == 3'h0) state_q <= st_ack;
                        else bit_q <= bit_q - 3'h1;
                     end
                  endcase
               end
            end
            st_ack: begin
               if (tick) begin
                  unique case (qtr_q)
                     2'h0: begin
                        if (phase_q == ph_data && cmd_q.is_read) begin
                           rsp.data <= shift_q;
                           rsp.data_valid <= 1'b1;
                           sda_out <= (left_q == 5'h01);
                        end else begin
                           sda_out <= 1'b1;
                        end
                     end
                     2'h1: scl_out <= 1'b1;
                     2'h2: if (!(phase_q == ph_data && cmd_q.is_read) && sda_f) nack_q <= 1'b1;
                     2'h3: begin
                        scl_out <= 1'b0;
                        bit_q <= 3'h7;
                        if (nack_q) begin
                           state_q <= st_stop;
                        end else unique case (phase_q)
                           ph_addr_w: begin
                              phase_q <= ph_sub;
                              shift_q <= {cmd_q.incr, cmd_q.reg_addr};
                              state_q <= st_bit;
                           end
                           ph_sub: begin
                              if (cmd_q.is_read) begin
                                 state_q <= st_rstart;
                              end else begin
                                 phase_q <= ph_data;
                                 shift_q <= wr_data;
                                 wr_take <= 1'b1;
                                 state_q <= st_bit;
                              end
                           end
                           ph_addr_r: begin
                              phase_q <= ph_data;
                              state_q <= st_bit;
                           end
                           ph_data: begin
                              left_q <= left_q - 5'h01;
                              if (left_q == 5'h01) begin
                                 state_q <= st_stop;
                              end else begin
                                 if (!cmd_q.is_read) begin
                                    shift_q <= wr_data;
                                    wr_take <= 1'b1;
                                 end
                                 state_q <= st_bit;
                              end
                           end
                        endcase
                     end
                  endcase
               end
            end
            st_stop: begin
               // Data rises while clock high
               if (tick) begin
                  unique case (qtr_q)
                     2'h0: sda_out <= 1'b0;
                     2'h1: scl_out <= 1'b1;
                     2'h2: sda_out <= 1'b1;
                     2'h3: state_q <= st_done;
                  endcase
               end
            end
            st_done: begin
               rsp.done <= 1'b1;
               rsp.nack <= nack_q;
               state_q <= st_idle;
            end
            default: state_q <= st_idle;
         endcase
      end
   end

   // Open-drain: enable low only when pulling low
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_ready <= 1'b0;
      end else begin
         cmd_ready <= (state_q == st_idle) && !bus_busy;
      end
   end

   assign scl_oe_n = scl_out;
   assign sda_oe_n = sda_out;
endmodule

// [tb/i2c_host_properties.sv]
`timescale 1ns/1ns
// Port-level checks of the two-wire master
module i2c_host_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_ready,
   input wire i2c_host_pkg::rsp_t rsp,
   input wire logic bus_busy,
   input wire logic select_out,
   input wire logic scl_in,
   input wire logic scl_oe_n,
   input wire logic sda_in,
   input wire logic sda_oe_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   // Framing seen on the wires; window covers the input filter delay
   a_idle_lines_free: assert property (cmd_ready |-> scl_oe_n && sda_oe_n)
      else $error("line driven while idle");
   a_start_sets_busy: assert property ($fell(sda_in) && scl_in ##1 !sda_in [*3] |-> ##[1:10] bus_busy)
      else $error("start not seen");
   a_stop_clears_busy: assert property ($rose(sda_in) && scl_in |-> ##[1:10] !bus_busy)
      else $error("stop not seen");
   a_ready_needs_free: assert property (cmd_ready |-> !bus_busy)
      else $error("ready while busy");
   a_select_after_reset: assert property (!$past(rst) |-> select_out)
      else $error("select low");
   a_stretch_waits: assert property (scl_oe_n && !scl_in && bus_busy |=> scl_oe_n)
      else $error("clock driven during stretch");
   a_done_one_cycle: assert property (rsp.done |=> !rsp.done)
      else $error("done held");
   a_nack_holds: assert property (!rsp.done |-> $stable(rsp.nack))
      else $error("nack changed without done");
   // Main scenarios
   c_nack: cover property (rsp.done && rsp.nack);
   c_read: cover property (rsp.data_valid);
   c_stretch: cover property (scl_oe_n && !scl_in && bus_busy);
endmodule
bind i2c_host i2c_host_properties u_props (.clk(clk), .rst(rst), .cmd_ready(cmd_ready), .rsp(rsp),
   .bus_busy(bus_busy), .select_out(select_out), .scl_in(scl_in), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
   .sda_oe_n(sda_oe_n));

// [tb/sensor_dev_model.sv]
`timescale 1ns/1ns
// Behavioural sensor slave; event driven, so any bus rate works
module sensor_dev_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic strap,
   input wire logic sel,
   input wire logic slow,
   output logic scl_rel,
   output logic sda_rel
);
   logic [7:0] regs [128] = '{default: 8'h00};
   logic [7:0] sh = 8'h00;
   logic [6:0] ptr = 7'h00;
   logic inc = 1'b0;
   logic act = 1'b0;
   int bitn = 0;
   int ph = 0;
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   // Start: address phase afresh, pointer kept for repeated start
   always @(negedge sda) if (scl) begin
      act = sel;
      ph = 0;
      bitn = -1;
      sda_rel = 1'b1;
   end
   // Stop frees the data line
   always @(posedge sda) if (scl) begin
      act = 1'b0;
      sda_rel = 1'b1;
   end
   // Rising clock: shift in, or watch the master acknowledge
   always @(posedge scl) if (act) begin
      if (bitn < 8 && ph != 3) sh = {sh[6:0], sda};
      else if (bitn == 8 && ph == 3 && sda) act = 1'b0;
   end
   // Falling clock: acknowledge, next data bit, optional stretch
   always @(negedge scl) if (act) begin
      if (bitn < 8) begin
         bitn++;
         if (bitn < 8) begin
            if (ph == 3 && bitn > 0) sda_rel = sh[7 - bitn];
         end else begin
            case (ph)
               0: if (sh[7:1] == {i2c_host_pkg::addr_fixed_bits, strap}) begin
                  sda_rel = 1'b0;
                  ph = sh[0] ? 3 : 1;
               end else act = 1'b0;
               1: begin
                  ptr = sh[6:0];
                  inc = sh[7];
                  sda_rel = 1'b0;
                  ph = 2;
               end
               2: begin
                  regs[ptr] = sh;
                  ptr = ptr + {6'h00, inc};
                  sda_rel = 1'b0;
               end
               default: sda_rel = 1'b1;
            endcase
         end
      end else begin
         bitn = 0;
         sda_rel = 1'b1;
         if (ph == 3) begin
            sh = regs[ptr];
            ptr = ptr + {6'h00, inc};
            sda_rel = sh[7];
         end
         if (slow) begin
            scl_rel = 1'b0;
            #2000;
            scl_rel = 1'b1;
         end
      end
   end
endmodule

// [tb/tb_i2c_host.sv]
`timescale 1ns/1ns
module tb_i2c_host;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   i2c_host_pkg::cmd_t cmd = '0;
   logic fast_mode = 1'b1;
   logic dev_strap = 1'b1;
   logic slow = 1'b0;
   logic [7:0] wbuf [16] = '{default: 8'h00};
   logic [7:0] rbuf [16];
   logic [7:0] wr_data;
   logic wr_take, cmd_ready, bus_busy, select_out, scl_oe_n, sda_oe_n, scl_rel, sda_rel, nack;
   i2c_host_pkg::rsp_t rsp;
   logic sda_glitch_n = 1'b1;
   wire scl_line = scl_oe_n & scl_rel;
   // A bench-made short low pulse on data exercises the input filter
   wire sda_line = sda_oe_n & sda_rel & sda_glitch_n;
   int widx = 0;
   int ridx = 0;
   int bad_count = 0;
   int checked = 0;
   assign wr_data = wbuf[widx[3:0]];
   // Short quarters keep the run brief
   i2c_host #(.quarter_fast(4), .quarter_std(8)) u_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd(cmd), .fast_mode(fast_mode), .wr_data(wr_data), .wr_take(wr_take), .cmd_ready(cmd_ready),
      .rsp(rsp), .bus_busy(bus_busy), .select_out(select_out), .scl_in(scl_line), .scl_out(),
      .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(), .sda_oe_n(sda_oe_n));
   sensor_dev_model dev (.scl(scl_line), .sda(sda_line), .strap(dev_strap), .sel(select_out),
      .slow(slow), .scl_rel(scl_rel), .sda_rel(sda_rel));
   ////////////////////////////////////////////////////////////////
   always #10 clk = ~clk;
   // Next write byte appears one cycle after the previous was taken
   always @(posedge clk) if (wr_take === 1'b1) #1 widx++;
   // Read pulse lasts one cycle, so it is caught at the edge ending it
   always @(posedge clk) if (rsp.data_valid === 1'b1) begin
      rbuf[ridx[3:0]] = rsp.data;
      ridx++;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // One command, presented for a single cycle once ready, then wait for done under a bound
   task automatic xfer(input logic rd, st, inc, input logic [6:0] ra, input logic [4:0] n);
      int t;
      t = 0;
      widx = 0;
      ridx = 0;
      while (cmd_ready !== 1'b1 && t < 100) begin
         @(posedge clk);
         #1;
         t++;
      end
      check("cmd ready", {7'h00, cmd_ready}, 8'h01);
      cmd = '{rd, st, inc, ra, n};
      cmd_valid = 1'b1;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      t = 0;
      while (rsp.done !== 1'b1 && t < 20000) begin
         @(posedge clk);
         #1;
         t++;
      end
      check("done", {7'h00, rsp.done}, 8'h01);
      nack = rsp.nack;
   endtask
   // Burst write then repeated-start burst read; both straps, both rates
   task automatic sc_burst(input logic b);
      dev_strap = b;
      fast_mode = !b;
      slow = b;
      for (int i = 0; i < 3; i++) wbuf[i] = 8'h81 + 8'h25 * 8'(i) + {7'h00, b};
      xfer(1'b0, b, 1'b1, 7'h20, 5'h03);
      check("write nack", {7'h00, nack}, 8'h00);
      for (int i = 0; i < 3; i++) check("reg", dev.regs[7'h20 + i], wbuf[i]);
      xfer(1'b1, b, 1'b1, 7'h20, 5'h03);
      check("read count", 8'(ridx), 8'h03);
      for (int i = 0; i < 3; i++) check("read data", rbuf[i], wbuf[i]);
   endtask
   // Without the increment flag every byte hits one register
   task automatic sc_fixed();
      fast_mode = 1'b1;
      slow = 1'b0;
      wbuf[0] = 8'h3c;
      wbuf[1] = 8'hc3;
      xfer(1'b0, 1'b1, 1'b0, 7'h40, 5'h02);
      check("fixed reg", dev.regs[7'h40], 8'hc3);
      check("next reg", dev.regs[7'h41], 8'h00);
      xfer(1'b1, 1'b1, 1'b0, 7'h40, 5'h02);
      for (int i = 0; i < 2; i++) check("fixed read", rbuf[i], 8'hc3);
   endtask
   // Wrong strap: no acknowledge, nothing stored, bus freed
   task automatic sc_nomatch();
      xfer(1'b0, 1'b0, 1'b1, 7'h50, 5'h01);
      check("addr nack", {7'h00, nack}, 8'h01);
      check("untouched", dev.regs[7'h50], 8'h00);
      // Stop reaches the busy flag only after the input filter delay
      repeat (8) @(posedge clk);
      #1;
      check("bus free", {7'h00, bus_busy}, 8'h00);
   endtask
   // A two-cycle data glitch and a zero-length command both leave the bus idle
   task automatic sc_quiet();
      cmd = '{1'b0, 1'b1, 1'b0, 7'h10, 5'h00};
      cmd_valid = 1'b1;
      sda_glitch_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      sda_glitch_n = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      check("glitch busy", {7'h00, bus_busy}, 8'h00);
      check("zero count", {7'h00, cmd_ready}, 8'h01);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("ready", {7'h00, cmd_ready}, 8'h01);
      check("select", {7'h00, select_out}, 8'h01);
      check("released", {6'h00, scl_oe_n, sda_oe_n}, 8'h03);
      sc_quiet();
      sc_burst(1'b0);
      sc_burst(1'b1);
      sc_fixed();
      sc_nomatch();
      close_out();
   end
   // Watchdog well beyond the expected run
   initial begin
      #1500000;
      bad_count++;
      close_out();
   end
endmodule
